// *** design/otc_top.sv ***
// oscillator configuration, protection and temperature trim with apb access
// assumes synchronous status inputs from the oscillator and the pll
`timescale 1ns/100ps
`default_nettype none

module otc_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic crystal_clock_ok,
  input wire logic pll_lock_detect,
  output logic ext_osc_on,
  output logic clock_monitor_en,
  output logic ref_from_crystal,
  output logic filter_enable,
  output logic [4:0] osc_filter_ratio,
  output logic [1:0] filter_window,
  output logic tc_comp_enable,
  output logic [4:0] temp_coeff_trim,
  output logic [9:0] irc_freq_trim,
  output logic crystal_pins_reserved,
  output logic osc_stable_flag,
  output logic pll_lock_flag,
  output logic crystal_selectable,
  output logic clock_monitor_reset,
  output logic irq
);

  // ==========================================================
  // apb decode
  wire logic setup_ph;
  wire logic wr_en;
  wire logic hit_trim_hi;
  wire logic hit_trim_lo;
  wire logic hit_osc;
  wire logic hit_guard;
  wire logic hit_clk_sel;
  wire logic hit_flags;
  wire logic hit_stat;
  wire logic hit_mask;
  wire logic hit_any;
  wire logic [7:0] wdata;

  assign setup_ph = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite && hit_any;
  assign wdata = pwdata[7:0];
  assign hit_trim_hi = paddr == otc_pkg::byte_addr(otc_pkg::IDX_TRIM_HI);
  assign hit_trim_lo = paddr == otc_pkg::byte_addr(otc_pkg::IDX_TRIM_LO);
  assign hit_osc = paddr == otc_pkg::byte_addr(otc_pkg::IDX_OSC_CFG);
  assign hit_guard = paddr == otc_pkg::byte_addr(otc_pkg::IDX_GUARD);
  assign hit_clk_sel = paddr == otc_pkg::byte_addr(otc_pkg::IDX_CLK_SEL);
  assign hit_flags = paddr == otc_pkg::byte_addr(otc_pkg::IDX_FLAGS);
  assign hit_stat = paddr == otc_pkg::byte_addr(otc_pkg::IDX_INT_STAT);
  assign hit_mask = paddr == otc_pkg::byte_addr(otc_pkg::IDX_INT_MASK);
  assign hit_any = hit_trim_hi || hit_trim_lo || hit_osc || hit_guard || hit_clk_sel
    || hit_flags || hit_stat || hit_mask;

  // ==========================================================
  // registers
  logic [7:0] osc_cfg_reg;
  logic [7:0] osc_cfg_next;
  logic [7:0] trim_hi_reg;
  logic [7:0] trim_lo_reg;
  logic guard_reg;
  logic clk_sel_reg;
  logic pins_reg;
  logic [3:0] int_stat_reg;
  logic [3:0] int_stat_next;
  logic [3:0] int_mask_reg;

  // gating looks at guard and select as they stand in the write cycle
  wire logic osc_wr_try;
  wire logic osc_wr_ok;
  wire logic trim_wr_ok;
  wire logic flag_clear;
  wire logic osc_en;

  assign osc_wr_try = wr_en && hit_osc;
  assign osc_wr_ok = osc_wr_try && !guard_reg && clk_sel_reg;
  assign trim_wr_ok = wr_en && (hit_trim_hi || hit_trim_lo) && !guard_reg;
  // trim writes also disturb the reference while the pll drives the bus
  assign flag_clear = osc_wr_ok || (trim_wr_ok && clk_sel_reg);
  assign osc_en = osc_cfg_reg[otc_pkg::OSC_EN_BIT];
  // the reserved-pins bit is read-only, so a write never lands there
  assign osc_cfg_next = {wdata[7:6], 1'b0, wdata[4:0]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_cfg_reg <= otc_pkg::OSC_CFG_RST;
    else if (osc_wr_ok)
      osc_cfg_reg <= osc_cfg_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trim_hi_reg <= otc_pkg::TRIM_HI_RST;
      trim_lo_reg <= otc_pkg::TRIM_LO_RST;
    end
    else if (trim_wr_ok)
    begin
      if (hit_trim_hi)
        trim_hi_reg <= {wdata[7:3], 1'b0, wdata[1:0]};
      else
        trim_lo_reg <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      guard_reg <= otc_pkg::GUARD_RST;
    else if (wr_en && hit_guard)
      guard_reg <= wdata != otc_pkg::GUARD_UNLOCK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_sel_reg <= otc_pkg::CLK_SEL_RST;
    else if (wr_en && hit_clk_sel && !guard_reg)
      clk_sel_reg <= wdata[0];
  end

  // sticky until the next reset, no write can clear it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pins_reg <= 1'b0;
    else if (osc_en)
      pins_reg <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_mask_reg <= otc_pkg::EV_NONE;
    else if (wr_en && hit_mask)
      int_mask_reg <= wdata[3:0];
  end

  // ==========================================================
  // status qualification
  logic stable_done;
  logic stable_rise;
  logic lock_done;
  logic lock_rise;
  logic loss_done;
  logic loss_rise;
  wire logic stable_cond;
  wire logic loss_cond;

  logic osc_seen_reg;

  // the stable flag falls with the loss itself, so remember that it was once qualified
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_seen_reg <= 1'b0;
    else
      osc_seen_reg <= osc_en && (osc_seen_reg || stable_done);
  end

  assign stable_cond = osc_en && crystal_clock_ok;
  assign loss_cond = osc_en && osc_seen_reg && !crystal_clock_ok;

  otc_qualifier u_stable
  (
    .pclk(pclk),
    .presetn(presetn),
    .restart(flag_clear),
    .cond(stable_cond),
    .count(16'(otc_pkg::OSC_STARTUP_CYC)),
    .done(stable_done),
    .rise(stable_rise)
  );

  otc_qualifier u_lock
  (
    .pclk(pclk),
    .presetn(presetn),
    .restart(flag_clear),
    .cond(pll_lock_detect),
    .count(16'(otc_pkg::LOCK_SETTLE_CYC)),
    .done(lock_done),
    .rise(lock_rise)
  );

  // a short glitch on the oscillator status is not taken as lost oscillation
  otc_qualifier u_loss
  (
    .pclk(pclk),
    .presetn(presetn),
    .restart(!osc_en),
    .cond(loss_cond),
    .count(16'(otc_pkg::MON_LOSS_CYC)),
    .done(loss_done),
    .rise(loss_rise)
  );

  // ==========================================================
  // interrupt status, write one to clear, a new event wins over the clear
  wire logic [3:0] events;
  wire logic [3:0] w1c;

  assign events = {osc_wr_try && !osc_wr_ok, loss_rise, lock_rise, stable_rise};
  assign w1c = (wr_en && hit_stat) ? wdata[3:0] : otc_pkg::EV_NONE;
  assign int_stat_next = (int_stat_reg & ~w1c) | events;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_stat_reg <= otc_pkg::EV_NONE;
    else
      int_stat_reg <= int_stat_next;
  end

  // ==========================================================
  // read mux and apb answer
  wire logic [7:0] osc_rd;
  wire logic [7:0] flags_rd;
  wire logic [7:0] rd_byte;

  assign osc_rd = {osc_cfg_reg[7:6], pins_reg, osc_cfg_reg[4:0]};
  assign flags_rd = {6'b00_0000, stable_done, lock_done};
  assign rd_byte = hit_trim_hi ? trim_hi_reg
    : hit_trim_lo ? trim_lo_reg
    : hit_osc ? osc_rd
    : hit_guard ? {7'b000_0000, guard_reg}
    : hit_clk_sel ? {7'b000_0000, clk_sel_reg}
    : hit_flags ? flags_rd
    : hit_stat ? {4'h0, int_stat_reg}
    : hit_mask ? {4'h0, int_mask_reg}
    : 8'h00;

  // one wait-free access phase: data is prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup_ph;
      pslverr <= setup_ph && !hit_any;
      prdata <= (setup_ph && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ==========================================================
  // derived controls, registered so every output comes from a flip-flop
  wire logic [4:0] tc_code;
  wire logic [4:0] ratio;

  assign tc_code = trim_hi_reg[7:otc_pkg::TC_TRIM_LSB];
  assign ratio = osc_cfg_reg[4:0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_osc_on <= 1'b0;
      clock_monitor_en <= 1'b0;
      ref_from_crystal <= 1'b0;
      filter_enable <= 1'b0;
      osc_filter_ratio <= 5'h00;
      filter_window <= otc_pkg::WIN_NARROW;
      tc_comp_enable <= 1'b0;
      temp_coeff_trim <= 5'h00;
      irc_freq_trim <= 10'h000;
      crystal_pins_reserved <= 1'b0;
      osc_stable_flag <= 1'b0;
      pll_lock_flag <= 1'b0;
      crystal_selectable <= 1'b0;
      clock_monitor_reset <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      ext_osc_on <= osc_en;
      clock_monitor_en <= osc_en;
      ref_from_crystal <= osc_en;
      filter_enable <= ratio != 5'h00;
      osc_filter_ratio <= ratio;
      filter_window <= osc_cfg_reg[otc_pkg::OSC_BW_BIT] ? otc_pkg::WIN_WIDE
        : otc_pkg::WIN_NARROW;
      // low four bits zero covers both neutral codes, with either sign bit
      tc_comp_enable <= tc_code[3:0] != 4'h0;
      temp_coeff_trim <= tc_code;
      irc_freq_trim <= {trim_hi_reg[1:0], trim_lo_reg};
      crystal_pins_reserved <= pins_reg;
      osc_stable_flag <= stable_done;
      pll_lock_flag <= lock_done;
      crystal_selectable <= stable_done;
      clock_monitor_reset <= loss_done;
      irq <= |(int_stat_next & int_mask_reg);
    end
  end

endmodule

`default_nettype wire

// *** design/otc_pkg.sv ***
// constants shared by the oscillator configuration and trim block
// assumes a 25 MHz bus clock and 8-bit registers on a 32-bit apb
package otc_pkg;

  // ==========================================================
  // register indexes, byte address is four times the index
  localparam logic [9:0] IDX_TRIM_HI = 10'h2f8;
  localparam logic [9:0] IDX_TRIM_LO = 10'h2f9;
  localparam logic [9:0] IDX_OSC_CFG = 10'h2fa;
  localparam logic [9:0] IDX_GUARD = 10'h2fb;
  localparam logic [9:0] IDX_CLK_SEL = 10'h300;
  localparam logic [9:0] IDX_FLAGS = 10'h301;
  localparam logic [9:0] IDX_INT_STAT = 10'h302;
  localparam logic [9:0] IDX_INT_MASK = 10'h303;

  // ==========================================================
  // field positions
  localparam int OSC_EN_BIT = 7;
  localparam int OSC_BW_BIT = 6;
  localparam int OSC_PINS_BIT = 5;
  localparam int TC_TRIM_LSB = 3;
  localparam int EV_STABLE = 0;
  localparam int EV_LOCK = 1;
  localparam int EV_MON_FAULT = 2;
  localparam int EV_REJECT = 3;

  // ==========================================================
  // reset values and codes
  localparam logic [7:0] OSC_CFG_RST = 8'h00;
  localparam logic [7:0] TRIM_HI_RST = 8'h03;
  localparam logic [7:0] TRIM_LO_RST = 8'hff;
  localparam logic GUARD_RST = 1'b0;
  localparam logic CLK_SEL_RST = 1'b1;
  localparam logic [7:0] GUARD_UNLOCK = 8'h26;
  localparam logic [3:0] EV_NONE = 4'h0;
  localparam logic [1:0] WIN_NARROW = 2'h1;
  localparam logic [1:0] WIN_WIDE = 2'h3;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 25;
  localparam int OSC_STARTUP_NS = 10000;
  localparam int LOCK_SETTLE_NS = 5000;
  localparam int MON_LOSS_NS = 200;
  localparam int OSC_STARTUP_CYC = (OSC_STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCK_SETTLE_CYC = (LOCK_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int MON_LOSS_CYC = (MON_LOSS_NS * CLK_MHZ + 999) / 1000;

  function automatic logic [11:0] byte_addr(input logic [9:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

endpackage

// *** design/otc_qualifier.sv ***
// holds a flag once a condition has stood for a number of cycles
// assumes cond is synchronous to pclk
`timescale 1ns/100ps
`default_nettype none

module otc_qualifier
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  input wire logic cond,
  input wire logic [15:0] count,
  output logic done,
  output logic rise
);

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic done_reg;
  logic done_next;
  logic rise_reg;
  wire logic reaching;

  // restart wins, so a flag cleared by software cannot re-set in the same cycle
  assign reaching = (cnt_reg + 16'h0001) >= count;
  assign done_next = !restart && cond && (done_reg || reaching);
  assign cnt_next = (restart || !cond || done_reg) ? 16'h0000 : cnt_reg + 16'h0001;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= 16'h0000;
      done_reg <= 1'b0;
      rise_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      rise_reg <= done_next && !done_reg;
    end
  end

  assign done = done_reg;
  assign rise = rise_reg;

endmodule

`default_nettype wire

// *** verif/otc_top_sva.sv ***
// checker for the oscillator configuration block
// assumes it is bound into otc_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module otc_top_chk
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic crystal_clock_ok,
  input wire logic ext_osc_on,
  input wire logic clock_monitor_en,
  input wire logic ref_from_crystal,
  input wire logic filter_enable,
  input wire logic [4:0] osc_filter_ratio,
  input wire logic [1:0] filter_window,
  input wire logic tc_comp_enable,
  input wire logic [4:0] temp_coeff_trim,
  input wire logic crystal_pins_reserved,
  input wire logic osc_stable_flag,
  input wire logic clock_monitor_reset
);
  // ==========================================================
  // shadow of the write gate, so accepted and refused writes can be told apart
  logic guard_reg;
  logic sel_reg;
  wire wr = psel && penable && pready && pwrite;
  wire cfg_wr = wr && paddr == 12'hbe8;
  wire cfg_ok = cfg_wr && !guard_reg && sel_reg;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      guard_reg <= 1'b0;
      sel_reg <= 1'b1;
    end
    else
    begin
      if (wr && paddr == 12'hbec) guard_reg <= pwdata[7:0] != 8'h26;
      if (wr && paddr == 12'hc00 && !guard_reg) sel_reg <= pwdata[0];
    end
  // ==========================================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  osc_mode_a:
  assert property (clock_monitor_en == ext_osc_on && ref_from_crystal == ext_osc_on)
    else $error("oscillator enable outputs disagree");
  pins_sticky_a:
  assert property (crystal_pins_reserved |=> crystal_pins_reserved)
    else $error("pins reserved bit cleared without reset");
  pins_set_a:
  assert property (ext_osc_on |=> crystal_pins_reserved)
    else $error("pins not reserved while oscillator on");
  window_code_a:
  assert property (filter_window == otc_pkg::WIN_NARROW || filter_window == otc_pkg::WIN_WIDE)
    else $error("filter window code illegal");
  filter_en_a:
  assert property (filter_enable == (osc_filter_ratio != 5'h00))
    else $error("filter enable does not follow ratio");
  tc_off_a:
  assert property (tc_comp_enable == (temp_coeff_trim[3:0] != 4'h0))
    else $error("compensation enable does not follow trim code");
  stable_drop_a:
  assert property (!crystal_clock_ok |-> ##3 !osc_stable_flag)
    else $error("stable flag kept without oscillation");
  mon_reset_a:
  assert property ($rose(clock_monitor_reset) |-> ext_osc_on && !$past(crystal_clock_ok, 3))
    else $error("monitor reset without loss");
  cfg_clear_a:
  assert property (cfg_ok |-> ##3 !osc_stable_flag)
    else $error("accepted write left stable flag set");
  cfg_reject_a:
  assert property (cfg_wr && !cfg_ok |=> $stable({ext_osc_on, osc_filter_ratio, filter_window})[*3])
    else $error("refused write changed configuration");
endmodule
bind otc_top otc_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .crystal_clock_ok(crystal_clock_ok), .ext_osc_on(ext_osc_on),
  .clock_monitor_en(clock_monitor_en), .ref_from_crystal(ref_from_crystal),
  .filter_enable(filter_enable), .osc_filter_ratio(osc_filter_ratio),
  .filter_window(filter_window), .tc_comp_enable(tc_comp_enable),
  .temp_coeff_trim(temp_coeff_trim), .crystal_pins_reserved(crystal_pins_reserved),
  .osc_stable_flag(osc_stable_flag), .clock_monitor_reset(clock_monitor_reset));
`default_nettype wire

// *** verif/otc_crystal_model.sv ***
// behavioural crystal source at the oscillator pins
// assumes enable is the block's oscillator enable output
`timescale 1ns/100ps
`default_nettype none
module otc_crystal_model
#(
  parameter int STARTUP_CYC = 20
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic lose,
  output logic clock_ok
);
  // ==========================================================
  // oscillation shows only after a startup delay; a commanded loss drops it at once
  int count_reg;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      count_reg <= 0;
    else if (!enable)
      count_reg <= 0;
    else if (count_reg < STARTUP_CYC)
      count_reg <= count_reg + 1;
  assign clock_ok = enable && !lose && count_reg == STARTUP_CYC;
endmodule
`default_nettype wire

// *** verif/osc_config_and_tc_trim_bench.sv ***
// self-checking bench for the oscillator configuration block
// assumes the crystal model at the pins and apb with no wait states
`timescale 1ns/100ps
`default_nettype none
module osc_config_and_tc_trim_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lock_in, lose, err;
  logic osc_ok, osc_on, mon_en, ref_x, f_en, tc_en, pins, stable, lock, sel_ok, mon_rst, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] ratio, tct;
  logic [1:0] win;
  logic [9:0] irc;
  logic [4:0] codes [4] = '{5'h00, 5'h10, 5'h01, 5'h1f};
  int n_fail, tests_run, i;
  otc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_clock_ok(osc_ok), .pll_lock_detect(lock_in), .ext_osc_on(osc_on),
    .clock_monitor_en(mon_en), .ref_from_crystal(ref_x), .filter_enable(f_en),
    .osc_filter_ratio(ratio), .filter_window(win), .tc_comp_enable(tc_en),
    .temp_coeff_trim(tct), .irc_freq_trim(irc), .crystal_pins_reserved(pins),
    .osc_stable_flag(stable), .pll_lock_flag(lock), .crystal_selectable(sel_ok),
    .clock_monitor_reset(mon_rst), .irq(irq));
  otc_crystal_model xtal (.pclk(pclk), .presetn(presetn), .enable(osc_on), .lose(lose),
    .clock_ok(osc_ok));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ==========================================================
  // bus and compare tasks
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no fixed wait is assumed; only the watchdog ends a hang
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, exp, rd);
  endtask
  task wait_stable;
    for (i = 0; i < 400 && stable !== 1'b1; i++)
      @(posedge pclk);
    chk("stable", 32'h0000_0001, 32'(stable));
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    end_of_test;
  end
  // ==========================================================
  // tests
  initial
  begin
    {presetn, psel, penable, pwrite, lock_in, lose} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    tick(5);
    presetn <= 1'b1;
    tick(2);
    chk("win", 32'h0000_0001, 32'(win));
    chk("irc", 32'h0000_03ff, 32'(irc));
    rdc("cfg", 12'hbe8, 32'h0000_0000);
    rdc("thi", 12'hbe0, 32'h0000_0003);
    rdc("tlo", 12'hbe4, 32'h0000_00ff);
    rdc("hole", 12'hbf0, 32'h0000_0000);
    chk("err", 32'h0000_0001, 32'(err));
    apb(1'b1, 12'hbec, 32'h0000_0000);
    apb(1'b1, 12'hbe8, 32'h0000_0080);
    rdc("cfg", 12'hbe8, 32'h0000_0000);
    chk("osc_on", 32'h0000_0000, 32'(osc_on));
    apb(1'b1, 12'hc0c, 32'h0000_0008);
    tick(2);
    chk("irq", 32'h0000_0001, 32'(irq));
    apb(1'b1, 12'hc0c, 32'h0000_0000);
    tick(2);
    chk("irq", 32'h0000_0000, 32'(irq));
    apb(1'b1, 12'hc0c, 32'h0000_0008);
    apb(1'b1, 12'hc08, 32'h0000_0008);
    tick(2);
    chk("irq", 32'h0000_0000, 32'(irq));
    rdc("ist", 12'hc08, 32'h0000_0000);
    apb(1'b1, 12'hbec, 32'h0000_0026);
    apb(1'b1, 12'hc00, 32'h0000_0000);
    apb(1'b1, 12'hbe8, 32'h0000_0080);
    rdc("cfg", 12'hbe8, 32'h0000_0000);
    apb(1'b1, 12'hc00, 32'h0000_0001);
    lock_in <= 1'b1;
    // wide bit and an integer ratio, as the pll setup calls for
    apb(1'b1, 12'hbe8, 32'h0000_00c3);
    rdc("cfg", 12'hbe8, 32'h0000_00e3);
    chk("osc_on", 32'h0000_0001, 32'(osc_on));
    chk("mon", 32'h0000_0001, 32'(mon_en));
    chk("ref", 32'h0000_0001, 32'(ref_x));
    chk("win", 32'h0000_0003, 32'(win));
    chk("fen", 32'h0000_0001, 32'(f_en));
    chk("ratio", 32'h0000_0003, 32'(ratio));
    wait_stable;
    chk("sel", 32'h0000_0001, 32'(sel_ok));
    chk("lock", 32'h0000_0001, 32'(lock));
    rdc("flags", 12'hc04, 32'h0000_0003);
    apb(1'b1, 12'hbe8, 32'h0000_0080);
    rdc("flags", 12'hc04, 32'h0000_0000);
    chk("lock", 32'h0000_0000, 32'(lock));
    chk("fen", 32'h0000_0000, 32'(f_en));
    wait_stable;
    lose <= 1'b1;
    for (i = 0; i < 30 && mon_rst !== 1'b1; i++)
      @(posedge pclk);
    chk("monrst", 32'h0000_0001, 32'(mon_rst));
    // stable and lock rose, monitor fault, and the earlier refused write
    rdc("ist", 12'hc08, 32'h0000_000f);
    lose <= 1'b0;
    apb(1'b1, 12'hbe8, 32'h0000_0000);
    rdc("cfg", 12'hbe8, 32'h0000_0020);
    chk("osc_on", 32'h0000_0000, 32'(osc_on));
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, 12'hbe0, {24'h00_0000, codes[k], 3'h3});
      tick(2);
      chk("tc", 32'(codes[k] != 5'h00 && codes[k] != 5'h10), 32'(tc_en));
      chk("tct", 32'(codes[k]), 32'(tct));
    end
    // frequency retrim after the temperature trim moved
    apb(1'b1, 12'hbe4, 32'h0000_0055);
    tick(2);
    chk("irc", 32'h0000_0355, 32'(irc));
    chk("pins", 32'h0000_0001, 32'(pins));
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    tick(2);
    chk("pins", 32'h0000_0000, 32'(pins));
    end_of_test;
  end
endmodule
`default_nettype wire
